// ===== pkg/fdtr_params.svh
// Constants of the transfer-termination and result-phase block.
// Assumes inclusion by bare name from the decoder, engine, top and testbench modules.
`ifndef FDTR_PARAMS_SVH
`define FDTR_PARAMS_SVH
`define FDTR_ADDR_MSR       8'h00
`define FDTR_ADDR_DATA      8'h04
`define FDTR_ADDR_IST       8'h08
`define FDTR_ADDR_IMASK     8'h0c
`define FDTR_MSR_RFM        7
`define FDTR_MSR_DIO        6
`define FDTR_MSR_EXEC       5
`define FDTR_MSR_BUSY       4
`define FDTR_IRQ_RES        0
`define FDTR_IRQ_INV        1
`define FDTR_IRQ_ABN        2
`define FDTR_IST_RESET      3'h0
`define FDTR_IMASK_RESET    3'h7
`define FDTR_INVALID_RESULT 8'h80
`define FDTR_ST0_ABN        8'h40
`define FDTR_ST1_OVR        8'h10
`define FDTR_PARAM_BYTES    4'h8
`define FDTR_RESULT_BYTES   3'h7
`define FDTR_OP_READ        5'h06
`define FDTR_OP_WRITE       5'h05
`define FDTR_OP_READ_DEL    5'h0c
`define FDTR_PIDX_HEAD      0
`define FDTR_PIDX_C         1
`define FDTR_PIDX_H         2
`define FDTR_PIDX_R         3
`define FDTR_PIDX_N         4
`define FDTR_PIDX_EOT       5
`define FDTR_SECTOR_BYTES   512
`endif

// ===== pkg/fdtr_pkg.sv
// Types of the transfer-termination and result-phase block.
// Assumes nothing beyond the constants header.
package fdtr_pkg;
  typedef enum logic [2:0] {PH_CMD, PH_CMD_PROC, PH_EXEC, PH_RES, PH_RES_PROC} fdtr_phase_t;
  typedef enum logic [1:0] {CMD_READ, CMD_WRITE, CMD_READ_DEL, CMD_NONE} fdtr_cmd_t;
endpackage

// ===== pkg/fdtr_xfer_if.sv
// Signals between the phase sequencer and the transfer engine.
// Assumes both ends share one clock and reset.
`timescale 1ns/1ps
interface fdtr_xfer_if;
  logic       start;
  logic       write_dir;
  logic [7:0] first_sec;
  logic [7:0] end_of_track_sector;
  logic       tc;
  logic       under;
  logic       over;
  logic       drain;
  logic       done;
  logic       abnormal;
  logic       overrun_seen;
  logic       finishing;
  logic [7:0] last_sec;
  modport ctl (output start, write_dir, first_sec, end_of_track_sector, tc, under, over, drain,
               input  done, abnormal, overrun_seen, finishing, last_sec);
  modport eng (input  start, write_dir, first_sec, end_of_track_sector, tc, under, over, drain,
               output done, abnormal, overrun_seen, finishing, last_sec);
endinterface

// ===== design/fdtr_decode.sv
// Opcode decoder for the first command byte.
// Assumes the low five bits carry the command code.
`timescale 1ns/1ps
`include "fdtr_params.svh"
module fdtr_decode (
  // Command byte
  input  wire logic [7:0]        opcode_in,
  // Decode result
  output logic                   valid_out,
  output fdtr_pkg::fdtr_cmd_t    kind_out
);
  wire [4:0] code = opcode_in[4:0];
  assign kind_out  = (code == `FDTR_OP_READ)     ? fdtr_pkg::CMD_READ :
                     (code == `FDTR_OP_WRITE)    ? fdtr_pkg::CMD_WRITE :
                     (code == `FDTR_OP_READ_DEL) ? fdtr_pkg::CMD_READ_DEL :
                                                   fdtr_pkg::CMD_NONE;
  assign valid_out = (kind_out != fdtr_pkg::CMD_NONE);
endmodule

// ===== design/fdtr_xfer.sv
// Transfer engine: counts drained bytes and sectors and decides the end.
// Assumes drain pulses once per byte the device takes from its buffer side.
`timescale 1ns/1ps
`include "fdtr_params.svh"
module fdtr_xfer #(
  parameter int SECTOR_BYTES = `FDTR_SECTOR_BYTES
) (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  // Sequencer side
  fdtr_xfer_if.eng  xf
);
  localparam int CW = $clog2(SECTOR_BYTES);
  logic          active_r;
  logic [CW-1:0] cnt_r;
  logic [7:0]    sec_r;
  logic          stop_r;
  logic          tcn_r;
  logic          imp_r;
  logic          ovr_r;
  logic          fin_r;
  logic          done_r;
  logic          abn_r;
  wire stop_any  = stop_r | xf.tc | xf.under | xf.over;
  wire tc_any    = tcn_r | xf.tc;
  wire imp_any   = imp_r | xf.under | xf.over;
  wire step      = active_r & (fin_r | xf.drain);
  wire last_byte = (cnt_r == CW'(SECTOR_BYTES - 1));
  wire eot_hit   = step & last_byte & (sec_r == xf.end_of_track_sector);
  wire stop_end  = step & last_byte & stop_any;
  wire stop_gap  = active_r & stop_any & (cnt_r == '0) & ~step;
  wire finish    = eot_hit | stop_end | stop_gap;
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      active_r <= 1'b0;
      cnt_r    <= '0;
      sec_r    <= 8'h00;
      stop_r   <= 1'b0;
      tcn_r    <= 1'b0;
      imp_r    <= 1'b0;
      ovr_r    <= 1'b0;
      fin_r    <= 1'b0;
      done_r   <= 1'b0;
      abn_r    <= 1'b0;
    end
    else
    begin
      done_r <= finish;
      if (finish)
        abn_r <= (eot_hit & ~tc_any) | imp_any;
      if (xf.start)
      begin
        active_r <= 1'b1;
        cnt_r    <= '0;
        sec_r    <= xf.first_sec;
        stop_r   <= 1'b0;
        tcn_r    <= 1'b0;
        imp_r    <= 1'b0;
        ovr_r    <= 1'b0;
        fin_r    <= 1'b0;
      end
      else if (active_r)
      begin
        stop_r <= stop_any;
        tcn_r  <= tc_any;
        imp_r  <= imp_any;
        ovr_r  <= ovr_r | xf.over;
        fin_r  <= ~finish & stop_any & (step ? ~last_byte : (cnt_r != '0));
        if (finish)
          active_r <= 1'b0;
        else if (step)
        begin
          cnt_r <= last_byte ? '0 : cnt_r + 1'b1;
          if (last_byte)
            sec_r <= sec_r + 8'h01;
        end
      end
    end
  end
  assign xf.done         = done_r;
  assign xf.abnormal     = abn_r;
  assign xf.overrun_seen = ovr_r;
  assign xf.finishing    = fin_r;
  assign xf.last_sec     = sec_r;
endmodule

// ===== design/fdtr_top.sv
// Command, execution and result phase sequencer with an APB register slave.
// Assumes an APB master on mclk_in and buffer-side strobes synchronous to it.
`timescale 1ns/1ps
`include "fdtr_params.svh"
module fdtr_top #(
  parameter int SECTOR_BYTES = `FDTR_SECTOR_BYTES
) (
  // Clock and reset
  input  wire logic        mclk_in,
  input  wire logic        rst_n_in,
  // APB slave
  input  wire logic [7:0]  paddr_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // Transfer events
  input  wire logic        terminal_count_input_in,
  input  wire logic        underrun_in,
  input  wire logic        overrun_in,
  input  wire logic        drain_in,
  // Interrupt
  output logic             irq_out
);
  logic                  rst_s1_r;
  logic                  rst_n;
  fdtr_pkg::fdtr_phase_t phase_r;
  fdtr_pkg::fdtr_cmd_t   cmd_r;
  logic                  busy_r;
  logic                  invalid_r;
  logic [3:0]            byte_idx_r;
  logic [2:0]            res_idx_r;
  logic [2:0]            res_cnt_r;
  logic [7:0]            param_mem [0:7];
  logic [7:0]            res_mem [0:6];
  logic [2:0]            ist_r;
  logic [2:0]            ist_nxt;
  logic [2:0]            imask_r;
  logic [31:0]           prdata_r;
  logic                  start_r;
  logic                  dec_valid;
  fdtr_pkg::fdtr_cmd_t   dec_kind;
  fdtr_xfer_if           xf ();

  // Reset release through two flip-flops.
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rst_s1_r <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_n    <= rst_s1_r;
    end
  end

  // Bus decode.
  wire setup     = psel_in & ~penable_in;
  wire acc       = psel_in & penable_in;
  wire sel_msr   = (paddr_in == `FDTR_ADDR_MSR);
  wire sel_data  = (paddr_in == `FDTR_ADDR_DATA);
  wire sel_ist   = (paddr_in == `FDTR_ADDR_IST);
  wire sel_imask = (paddr_in == `FDTR_ADDR_IMASK);
  wire mapped    = sel_msr | sel_data | sel_ist | sel_imask;
  wire wr_acc    = acc & pwrite_in & mapped;
  wire rd_acc    = acc & ~pwrite_in & mapped;
  wire data_wr   = wr_acc & sel_data & (phase_r == fdtr_pkg::PH_CMD);
  wire data_rd   = rd_acc & sel_data & (phase_r == fdtr_pkg::PH_RES);
  wire ist_wr    = wr_acc & sel_ist;

  // Status word.
  wire rfm  = (phase_r == fdtr_pkg::PH_CMD) | (phase_r == fdtr_pkg::PH_RES);
  wire data_direction_flag  = (phase_r == fdtr_pkg::PH_RES);
  wire exec = (phase_r == fdtr_pkg::PH_EXEC);
  wire [7:0] main_status_word = {rfm, data_direction_flag, exec, busy_r, 4'h0};

  wire last_param = (byte_idx_r == `FDTR_PARAM_BYTES + 4'h1);
  wire res_done   = (res_idx_r == res_cnt_r);
  wire [7:0] st0  = (xf.abnormal ? `FDTR_ST0_ABN : 8'h00)
                    | {5'h00, param_mem[`FDTR_PIDX_HEAD][2:0]};
  wire [7:0] st1  = xf.overrun_seen ? `FDTR_ST1_OVR : 8'h00;
  wire xfer_end   = (phase_r == fdtr_pkg::PH_EXEC) & xf.done;
  wire inv_enter  = (phase_r == fdtr_pkg::PH_CMD_PROC) & invalid_r;

  fdtr_decode u_decode (
    .opcode_in (pwdata_in[7:0]),
    .valid_out (dec_valid),
    .kind_out  (dec_kind)
  );

  assign xf.start     = start_r;
  assign xf.write_dir = (cmd_r == fdtr_pkg::CMD_WRITE);
  assign xf.first_sec = param_mem[`FDTR_PIDX_R];
  assign xf.end_of_track_sector       = param_mem[`FDTR_PIDX_EOT];
  assign xf.tc        = terminal_count_input_in;
  assign xf.under     = underrun_in;
  assign xf.over      = overrun_in;
  assign xf.drain     = drain_in;

  fdtr_xfer #(
    .SECTOR_BYTES (SECTOR_BYTES)
  ) u_xfer (
    .clk_in   (mclk_in),
    .rst_n_in (rst_n),
    .xf       (xf)
  );

  // Phase sequencer.
  always_ff @(posedge mclk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase_r    <= fdtr_pkg::PH_CMD;
      cmd_r      <= fdtr_pkg::CMD_NONE;
      busy_r     <= 1'b0;
      invalid_r  <= 1'b0;
      byte_idx_r <= 4'h0;
      res_idx_r  <= 3'h0;
      res_cnt_r  <= 3'h0;
      start_r    <= 1'b0;
    end
    else
    begin
      start_r <= 1'b0;
      unique case (phase_r)
        fdtr_pkg::PH_CMD:
          if (data_wr)
          begin
            byte_idx_r <= byte_idx_r + 4'h1;
            phase_r    <= fdtr_pkg::PH_CMD_PROC;
            if (byte_idx_r == 4'h0)
            begin
              busy_r    <= 1'b1;
              cmd_r     <= dec_kind;
              invalid_r <= ~dec_valid;
            end
          end
        fdtr_pkg::PH_CMD_PROC:
          if (invalid_r)
          begin
            res_idx_r <= 3'h0;
            res_cnt_r <= 3'h1;
            phase_r   <= fdtr_pkg::PH_RES;
          end
          else if (last_param)
          begin
            start_r <= 1'b1;
            phase_r <= fdtr_pkg::PH_EXEC;
          end
          else
            phase_r <= fdtr_pkg::PH_CMD;
        fdtr_pkg::PH_EXEC:
          if (xf.done)
          begin
            res_idx_r <= 3'h0;
            res_cnt_r <= `FDTR_RESULT_BYTES;
            phase_r   <= fdtr_pkg::PH_RES;
          end
        fdtr_pkg::PH_RES:
          if (data_rd)
          begin
            res_idx_r <= res_idx_r + 3'h1;
            phase_r   <= fdtr_pkg::PH_RES_PROC;
          end
        fdtr_pkg::PH_RES_PROC:
          if (res_done)
          begin
            busy_r     <= 1'b0;
            invalid_r  <= 1'b0;
            byte_idx_r <= 4'h0;
            phase_r    <= fdtr_pkg::PH_CMD;
          end
          else
            phase_r <= fdtr_pkg::PH_RES;
        default:
          phase_r <= fdtr_pkg::PH_CMD;
      endcase
    end
  end

  // Parameter and result storage.
  always_ff @(posedge mclk_in)
  begin
    if (data_wr && byte_idx_r != 4'h0)
      param_mem[byte_idx_r[2:0] - 3'h1] <= pwdata_in[7:0];
    if (inv_enter)
      res_mem[0] <= `FDTR_INVALID_RESULT;
    if (xfer_end)
    begin
      res_mem[0] <= st0;
      res_mem[1] <= st1;
      res_mem[2] <= 8'h00;
      res_mem[3] <= param_mem[`FDTR_PIDX_C];
      res_mem[4] <= param_mem[`FDTR_PIDX_H];
      res_mem[5] <= xf.last_sec;
      res_mem[6] <= param_mem[`FDTR_PIDX_N];
    end
  end

  // Sticky interrupt status; a set in the same cycle as a clear wins.
  wire [2:0] ist_set = {xfer_end & xf.abnormal, inv_enter, xfer_end};
  wire       first_rd = data_rd & (res_idx_r == 3'h0);
  wire [2:0] ist_clr = (ist_wr ? pwdata_in[2:0] : 3'h0) | {2'b00, first_rd};
  assign ist_nxt = (ist_r & ~ist_clr) | ist_set;

  always_ff @(posedge mclk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ist_r   <= `FDTR_IST_RESET;
      imask_r <= `FDTR_IMASK_RESET;
    end
    else
    begin
      ist_r <= ist_nxt;
      if (wr_acc && sel_imask)
        imask_r <= pwdata_in[2:0];
    end
  end

  // Read data is captured in the setup cycle.
  wire [31:0] rd_mux = sel_msr   ? {24'h0, main_status_word} :
                       sel_data  ? (data_direction_flag ? {24'h0, res_mem[res_idx_r]} : 32'h0) :
                       sel_ist   ? {29'h0, ist_r} :
                       sel_imask ? {29'h0, imask_r} : 32'h0;

  always_ff @(posedge mclk_in or negedge rst_n)
  begin
    if (!rst_n)
      prdata_r <= 32'h0;
    else if (setup && !pwrite_in)
      prdata_r <= rd_mux;
  end

  assign prdata_out  = prdata_r;
  assign pready_out  = 1'b1;
  assign pslverr_out = acc & ~mapped;
  assign irq_out     = |(ist_r & imask_r);

  // Checks.
  property p_end_to_result;
    @(posedge mclk_in) disable iff (!rst_n)
    xfer_end |=> (phase_r == fdtr_pkg::PH_RES) && rfm && data_direction_flag && busy_r;
  endproperty
  a_end_to_result: assert property (p_end_to_result)
    else $error("transfer end did not open the result phase");

  property p_tc_finishes;
    @(posedge mclk_in) disable iff (!rst_n)
    (exec && terminal_count_input_in && !xf.done) |-> ##[1:600] xf.done;
  endproperty
  a_tc_finishes: assert property (p_tc_finishes)
    else $error("terminal count did not end the transfer in time");

  property p_st0_status;
    @(posedge mclk_in) disable iff (!rst_n)
    xfer_end |=> (res_mem[0][6] == $past(xf.abnormal)) && (res_mem[5] == $past(xf.last_sec));
  endproperty
  a_st0_status: assert property (p_st0_status)
    else $error("result status does not match the ending");

  property p_no_count_idle;
    @(posedge mclk_in) disable iff (!rst_n)
    (exec && !drain_in && !xf.finishing && !terminal_count_input_in && !underrun_in
     && !overrun_in && !xf.done) |=> !xf.done;
  endproperty
  a_no_count_idle: assert property (p_no_count_idle)
    else $error("transfer ended without a drained byte or stop");

  property p_irq_start;
    @(posedge mclk_in) disable iff (!rst_n)
    (xfer_end && imask_r[`FDTR_IRQ_RES]) |=> irq_out;
  endproperty
  a_irq_start: assert property (p_irq_start)
    else $error("no interrupt at result phase start");

  property p_irq_hold;
    @(posedge mclk_in) disable iff (!rst_n)
    (ist_r[0] && !first_rd && !(ist_wr && pwdata_in[0])) |=> ist_r[0];
  endproperty
  a_irq_hold: assert property (p_irq_hold)
    else $error("result interrupt dropped before the first read");

  property p_ready_again;
    @(posedge mclk_in) disable iff (!rst_n)
    (phase_r == fdtr_pkg::PH_RES_PROC && res_done) |=> rfm && !data_direction_flag && !busy_r;
  endproperty
  a_ready_again: assert property (p_ready_again)
    else $error("status not ready for a command after results");

  property p_ignore_write;
    @(posedge mclk_in) disable iff (!rst_n)
    (wr_acc && sel_data && phase_r != fdtr_pkg::PH_CMD
     && !(phase_r == fdtr_pkg::PH_RES_PROC && res_done)) |=> $stable(byte_idx_r);
  endproperty
  a_ignore_write: assert property (p_ignore_write)
    else $error("command byte taken outside the command phase");

  property p_bad_opcode;
    @(posedge mclk_in) disable iff (!rst_n)
    (data_wr && byte_idx_r == 4'h0 && !dec_valid) |=> invalid_r ##1 !exec;
  endproperty
  a_bad_opcode: assert property (p_bad_opcode)
    else $error("invalid opcode was not flagged");

  property p_invalid_status;
    @(posedge mclk_in) disable iff (!rst_n)
    inv_enter |=> rfm && data_direction_flag && busy_r && (res_mem[0] == 8'h80) && (res_cnt_r == 3'h1);
  endproperty
  a_invalid_status: assert property (p_invalid_status)
    else $error("invalid opcode result not presented");

  property p_invalid_return;
    @(posedge mclk_in) disable iff (!rst_n)
    (data_rd && invalid_r) |=> ##1 (phase_r == fdtr_pkg::PH_CMD) && !busy_r;
  endproperty
  a_invalid_return: assert property (p_invalid_return)
    else $error("no return to command phase after invalid result");

  property p_rfm_drop;
    @(posedge mclk_in) disable iff (!rst_n)
    data_wr |=> !rfm;
  endproperty
  a_rfm_drop: assert property (p_rfm_drop)
    else $error("request bit stayed high after a command write");

  c_invalid: cover property (@(posedge mclk_in) disable iff (!rst_n) inv_enter);
  c_normal_end: cover property (@(posedge mclk_in) disable iff (!rst_n)
    xfer_end && !xf.abnormal);
  c_abnormal_end: cover property (@(posedge mclk_in) disable iff (!rst_n)
    xfer_end && xf.abnormal);
  c_results_read: cover property (@(posedge mclk_in) disable iff (!rst_n)
    phase_r == fdtr_pkg::PH_RES_PROC && res_done && !invalid_r);
endmodule

// ===== bench/fdtr_dma_model.sv
// Far-side model: a DMA channel that drains buffered bytes and raises stop events.
// Assumes one clock shared with the block; the bench calls its tasks.
`timescale 1ns/1ps
module fdtr_dma_model (
  // Clock
  input  wire logic clk_in,
  // Transfer events
  output logic      tc_out,
  output logic      under_out,
  output logic      over_out,
  output logic      drain_out
);
  initial {tc_out, under_out, over_out, drain_out} = 4'h0;
  // Sends n one-cycle byte pulses with gap + 1 idle cycles between, then the chosen stop event.
  task automatic run(input int n, input int gap, input int kind);
    repeat (n)
    begin
      @(posedge clk_in) drain_out <= 1'b1;
      @(posedge clk_in) drain_out <= 1'b0;
      repeat (gap) @(posedge clk_in);
    end
    @(posedge clk_in);
    tc_out    <= (kind == 0);
    under_out <= (kind == 1);
    over_out  <= (kind == 2);
    @(posedge clk_in);
    under_out <= 1'b0;
    over_out  <= 1'b0;
  endtask
  // Releases terminal count late; a lingering request is simply tolerated.
  task automatic idle();
    @(posedge clk_in) tc_out <= 1'b0;
  endtask
endmodule

// ===== bench/tb.sv
// Self-checking bench: APB host plus DMA model around the sequencer.
// Assumes the sequencer answers every APB access with pready.
`timescale 1ns/1ps
`include "fdtr_params.svh"
module tb;
  localparam int SB = 4;
  logic        mclk_in;
  logic        rst_n_in;
  logic [7:0]  paddr_in;
  logic        psel_in;
  logic        penable_in;
  logic        pwrite_in;
  logic [31:0] pwdata_in;
  logic [31:0] prdata_out;
  logic        pready_out;
  logic        pslverr_out;
  logic        tc;
  logic        under;
  logic        over;
  logic        drain;
  logic        irq_out;
  int          num_errors = 0;
  int          check_count = 0;
  logic [31:0] exp_q[$];
  logic [31:0] seen_v;
  event        seen_ev;
  int          ops[5] = '{6, 5, 12, 6, 6};
  int          kd[5] = '{3, 0, 2, 1, 0};
  int          nb[5] = '{2 * SB, SB + 2, 3, SB + 1, SB};
  int          fs[5] = '{2, 2, 1, 2, 2};
  fdtr_top #(.SECTOR_BYTES(SB)) uut (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .paddr_in(paddr_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out),
    .terminal_count_input_in(tc), .underrun_in(under), .overrun_in(over),
    .drain_in(drain), .irq_out(irq_out));
  fdtr_dma_model dma (.clk_in(mclk_in), .tc_out(tc), .under_out(under),
    .over_out(over), .drain_out(drain));
  task automatic chk(input logic [31:0] s, input logic [31:0] e, input string what);
    check_count++;
    if (s !== e)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    @(posedge mclk_in);
    psel_in    <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in  <= w;
    paddr_in   <= a;
    pwdata_in  <= d;
    @(posedge mclk_in);
    penable_in <= 1'b1;
    @(posedge mclk_in);
    while (pready_out !== 1'b1)
      @(posedge mclk_in);
    q = prdata_out;
    err = pslverr_out;
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        x;
    apb(1'b1, a, d, q, x);
  endtask
  task automatic rd_exp(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    logic        x;
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0, q, x);
    seen_v = q;
    -> seen_ev;
  endtask
  // Host waits for the status pattern before each data access that it expects to be taken.
  task automatic poll(input logic [7:0] m, input logic [7:0] w);
    logic [31:0] q;
    logic        x;
    int          n;
    n = 0;
    q = 32'h0;
    while (((q[7:0] & m) !== w) && n < 100)
    begin
      apb(1'b0, `FDTR_ADDR_MSR, 32'h0, q, x);
      n++;
    end
    chk({24'h0, q[7:0] & m}, {24'h0, w}, "status poll");
  endtask
  always @(seen_ev) chk(seen_v, exp_q.pop_front(), "register read");
  initial
  begin
    mclk_in = 1'b0;
    forever #4 mclk_in = ~mclk_in;
  end
  initial
  begin
    repeat (30000) @(posedge mclk_in);
    num_errors++;
    end_of_test();
  end
  initial
  begin
    logic [31:0] q;
    logic        e;
    logic [7:0]  op;
    logic [7:0]  p[8];
    logic [7:0]  r[7];
    {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = '0;
    rst_n_in = 1'b0;
    repeat (10) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    q = 32'($urandom(32'ha2f0));
    rd_exp(`FDTR_ADDR_MSR, 32'h80);
    rd_exp(`FDTR_ADDR_IMASK, 32'h7);
    rd_exp(`FDTR_ADDR_IST, 32'h0);
    rd_exp(`FDTR_ADDR_DATA, 32'h0);
    apb(1'b0, 8'h10, 32'h0, q, e);
    chk({31'h0, e}, 32'h1, "unmapped error");
    chk({31'h0, irq_out}, 32'h0, "irq after reset");
    wr(`FDTR_ADDR_IMASK, 32'h1);
    repeat (3)
    begin
      do op = 8'($urandom);
      while (op[4:0] == 5'h05 || op[4:0] == 5'h06 || op[4:0] == 5'h0c);
      poll(8'hc0, 8'h80);
      wr(`FDTR_ADDR_DATA, {24'h0, op});
      poll(8'h80, 8'h80);
      rd_exp(`FDTR_ADDR_MSR, 32'hd0);
      rd_exp(`FDTR_ADDR_DATA, {24'h0, `FDTR_INVALID_RESULT});
      rd_exp(`FDTR_ADDR_MSR, 32'h80);
      rd_exp(`FDTR_ADDR_IST, 32'h2);
      wr(`FDTR_ADDR_IST, 32'h7);
    end
    for (int k = 0; k < 5; k++)
    begin
      foreach (p[i]) p[i] = 8'($urandom);
      p[0] = p[0] & 8'h07;
      p[3] = 8'h01;
      p[5] = (k == 0) ? 8'h02 : 8'h05;
      r = '{(kd[k] != 0 ? `FDTR_ST0_ABN : 8'h00) | p[0], (kd[k] == 2 ? `FDTR_ST1_OVR : 8'h00),
            8'h00, p[1], p[2], 8'(fs[k]), p[4]};
      poll(8'hc0, 8'h80);
      wr(`FDTR_ADDR_DATA, {24'h0, 8'(ops[k]) | (8'($urandom) & 8'he0)});
      foreach (p[i])
      begin
        poll(8'hc0, 8'h80);
        wr(`FDTR_ADDR_DATA, {24'h0, p[i]});
      end
      wr(`FDTR_ADDR_DATA, 32'hff);
      dma.run(nb[k], k, kd[k]);
      poll(8'hc0, 8'hc0);
      wr(`FDTR_ADDR_DATA, 32'h06);
      chk({31'h0, irq_out}, 32'h1, "irq at result start");
      foreach (r[i])
      begin
        poll(8'hc0, 8'hc0);
        if (i == 1)
          chk({31'h0, irq_out}, 32'h0, "irq after first read");
        rd_exp(`FDTR_ADDR_DATA, {24'h0, r[i]});
      end
      rd_exp(`FDTR_ADDR_MSR, 32'h80);
      rd_exp(`FDTR_ADDR_IST, kd[k] != 0 ? 32'h4 : 32'h0);
      wr(`FDTR_ADDR_IST, 32'h7);
      dma.idle();
    end
    repeat (4) @(posedge mclk_in);
    end_of_test();
  end
endmodule
